// >>> hdl/dtb_defs.svh
`ifndef DTB_DEFS_SVH
`define DTB_DEFS_SVH

// ****************************************************************
// trigger mode codes carried by trigger_mode_field
// ****************************************************************
`define DTB_MODE_A_ONLY      4'h0
`define DTB_MODE_A_OR_B      4'h1
`define DTB_MODE_A_THEN_B    4'h2
`define DTB_MODE_EV_B        4'h3
`define DTB_MODE_A_THEN_EV_B 4'h4
`define DTB_MODE_FULL_AB     4'h5
`define DTB_MODE_FULL_ANB    4'h6
`define DTB_MODE_INSIDE      4'h7
`define DTB_MODE_OUTSIDE     4'h8

// ****************************************************************
// capture fifo sizing and reset values
// ****************************************************************
`define DTB_FIFO_DEPTH       8
`define DTB_FIFO_FULL        4'h8
`define DTB_COUNT_RESET      4'h0
`define DTB_PTR_RESET        3'h0
`define DTB_OPCODE_RESET     8'h00

`endif

// >>> hdl/dtb_pkg.sv
package dtb_pkg;

   // ****************************************************************
   // debug control bits, loaded as one word on ctrl_wr
   // ****************************************************************
   typedef struct packed {
      logic debug_module_enable;
      logic run_active_control;
      logic cpu_break_enable;
      logic breakpoint_kind_select;  // 1 = tag-type, 0 = force-type
      logic comp_a_dir_qualify_en;
      logic comp_a_dir_value;        // 1 = read, 0 = write
      logic comp_b_dir_qualify_en;
      logic comp_b_dir_value;
   } dtb_ctrl_t;

   // trigger control bits, live levels
   typedef struct packed {
      logic [3:0] trigger_mode_field;
      logic       fetch_qualify_select;  // 1 = opcode tracked triggers
      logic       trace_start_select;    // 1 = begin trace, 0 = end trace
   } dtb_trig_t;

   // one cpu bus cycle
   typedef struct packed {
      logic        valid;
      logic        opfetch;
      logic        rw;                   // 1 = read
      logic [15:0] addr;
      logic [7:0]  rdata;
      logic [7:0]  wdata;
   } dtb_bus_t;

   typedef enum logic [2:0] {
      st_idle  = 3'b001,
      st_wait  = 3'b010,
      st_trace = 3'b100
   } dtb_state_t;

endpackage

// >>> hdl/dtb_fifo_mem.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// capture storage, registered read port
// ****************************************************************
module dtb_fifo_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_idx,
   output logic      [WIDTH-1:0] rd_data_r
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rd_data_nxt;

   // storage cells carry no reset, only the read register does
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_comb begin
      rd_data_nxt = mem[rd_idx];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

endmodule

`default_nettype wire

// >>> hdl/dtb_trigger_core.sv
// What this block does
// - tags go out at fetch; only executed tagged opcodes act.
// - force request holds until the cpu acknowledges at a boundary.
// - an executed tagged opcode is replaced by the halt or trap opcode.
// - fetch qualify takes comparator events from executed tags.
// - four-bit mode field selects one of nine modes.
// - trace start select picks begin or circular end trace.
// - arming sets run flag, clears match flags and count.
// - begin runs end on full fifo; end runs on trigger.
// - run control or enable written low stops the run.
// - event-only modes store data bytes; others store flow addresses.
// - event-only modes always run as begin traces.
// - each comparator may also require a read/write direction.
// - with break enabled, triggers request a cpu break.
// - a-only matches a; a-or-b matches either.
// - a-then-b fires on b after an earlier a match.
// - full a-and-b-data: address a, data equal to b low.
// - full a-and-not-b-data: address a, data unequal to b low.
// - tag breaks in full modes use the a address match.
// - event-only b stores data on each b match.
// - a-then-event-only-b stores on b matches after a.
// - inside fires for a<=addr<=b; outside otherwise.
// - without halt permission a break uses the trap opcode.
// - fifo holds eight entries; full when all are valid.
`timescale 1ns/1ns
`default_nettype none
`include "dtb_defs.svh"

module dtb_trigger_core #(
   parameter logic [7:0] HALT_OPCODE = 8'h01,  // value arbitrary
   parameter logic [7:0] TRAP_OPCODE = 8'h02   // value arbitrary
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              ctrl_wr,
   input  wire dtb_pkg::dtb_ctrl_t ctrl_in,
   input  wire dtb_pkg::dtb_trig_t trig_cfg,
   input  wire logic [15:0]       comp_a_val,
   input  wire logic [15:0]       comp_b_val,
   input  wire dtb_pkg::dtb_bus_t bus,
   input  wire logic              cof_valid,
   input  wire logic [15:0]       cof_addr,
   input  wire logic              exec_valid,
   input  wire logic              exec_tag_a,
   input  wire logic              exec_tag_b,
   input  wire logic              exec_tag_brk,
   input  wire logic              break_ack,
   input  wire logic              halt_mode_permit,
   input  wire logic [2:0]        fifo_rd_idx,
   output logic                   run_active_flag_r,
   output logic                   match_a_flag_r,
   output logic                   match_b_flag_r,
   output logic [3:0]             fifo_fill_count_r,
   output logic [15:0]            fifo_rd_data_r,
   output logic                   tag_a_r,
   output logic                   tag_b_r,
   output logic                   tag_brk_r,
   output logic                   force_break_r,
   output logic                   exec_subst_r,
   output logic [7:0]             subst_opcode_r
);

   // ********************************
   // helpers
   // ********************************
   function automatic logic dir_ok(input logic en, input logic val, input logic rw);
      dir_ok = !en || (val == rw);
   endfunction

   // mode combination of comparator events
   function automatic logic mode_hit(input logic [3:0] mode, input logic a, input logic b,
                                     input logic a_seen);
      case (mode)
         `DTB_MODE_A_ONLY:      mode_hit = a;
         `DTB_MODE_A_OR_B:      mode_hit = a || b;
         `DTB_MODE_A_THEN_B:    mode_hit = b && a_seen;
         `DTB_MODE_EV_B:        mode_hit = b;
         `DTB_MODE_A_THEN_EV_B: mode_hit = b && a_seen;
         `DTB_MODE_FULL_AB,
         `DTB_MODE_FULL_ANB,
         `DTB_MODE_INSIDE,
         `DTB_MODE_OUTSIDE:     mode_hit = a;
         default:               mode_hit = 1'b0;
      endcase
   endfunction

   // ********************************
   // comparators
   // ********************************
   dtb_pkg::dtb_ctrl_t ctrl_r, ctrl_nxt;
   dtb_pkg::dtb_state_t state_r, state_nxt;
   logic [3:0]  mode;
   logic        running, event_only, begin_type, full_mode;
   logic        dir_a, dir_b, a_addr, b_addr, data_eq, a_side, a_ev, b_ev, trig;
   logic [7:0]  data_sel;

   // comparator a direction bits also pick the write bus for data compares
   always_comb begin
      mode       = trig_cfg.trigger_mode_field;
      running    = (state_r != dtb_pkg::st_idle);
      event_only = (mode == `DTB_MODE_EV_B) || (mode == `DTB_MODE_A_THEN_EV_B);
      begin_type = event_only || trig_cfg.trace_start_select;
      full_mode  = (mode == `DTB_MODE_FULL_AB) || (mode == `DTB_MODE_FULL_ANB);
      dir_a      = dir_ok(ctrl_r.comp_a_dir_qualify_en, ctrl_r.comp_a_dir_value, bus.rw);
      dir_b      = dir_ok(ctrl_r.comp_b_dir_qualify_en, ctrl_r.comp_b_dir_value, bus.rw);
      data_sel   = (ctrl_r.comp_a_dir_qualify_en && !ctrl_r.comp_a_dir_value) ?
                   bus.wdata : bus.rdata;
      data_eq    = (data_sel == comp_b_val[7:0]);
      a_addr     = bus.valid && dir_a && (bus.addr == comp_a_val);
      b_addr     = bus.valid && dir_b && (bus.addr == comp_b_val);
      case (mode)
         `DTB_MODE_FULL_AB:  a_side = a_addr && data_eq;
         `DTB_MODE_FULL_ANB: a_side = a_addr && !data_eq;
         `DTB_MODE_INSIDE:   a_side = bus.valid && dir_a && (bus.addr >= comp_a_val)
                                      && (bus.addr <= comp_b_val);
         `DTB_MODE_OUTSIDE:  a_side = bus.valid && dir_a && ((bus.addr < comp_a_val)
                                      || (bus.addr > comp_b_val));
         default:            a_side = a_addr;
      endcase
      // tracked events only count once the tagged opcode executes
      if (trig_cfg.fetch_qualify_select) begin
         a_ev = exec_valid && exec_tag_a;
         b_ev = exec_valid && exec_tag_b;
      end else begin
         a_ev = a_side;
         b_ev = b_addr;
      end
      trig = running && mode_hit(mode, a_ev, b_ev, match_a_flag_r);
   end

   // ********************************
   // run control and capture
   // ********************************
   logic        arm, stop, wr_en;
   logic [15:0] wr_data;
   logic [2:0]  wptr_r, wptr_nxt;
   logic [3:0]  count_nxt;
   logic        run_nxt, ma_nxt, mb_nxt;

   // a write that drops either enable stops the run with no drain
   always_comb begin
      ctrl_nxt  = ctrl_wr ? ctrl_in : ctrl_r;
      arm       = ctrl_wr && ctrl_in.run_active_control && ctrl_in.debug_module_enable;
      stop      = ctrl_wr && !arm;
      wr_en     = 1'b0;
      state_nxt = state_r;
      case (state_r)
         dtb_pkg::st_idle: begin
            state_nxt = state_r;
         end
         dtb_pkg::st_wait: begin
            if (event_only) begin
               wr_en = trig;
            end else if (!begin_type) begin
               wr_en = cof_valid;  // end trace stores circularly from arming
               if (trig) begin
                  state_nxt = dtb_pkg::st_idle;
               end
            end else if (trig) begin
               state_nxt = dtb_pkg::st_trace;
            end
         end
         dtb_pkg::st_trace: begin
            wr_en = cof_valid;
         end
         default: begin
            state_nxt = dtb_pkg::st_idle;
         end
      endcase
      // begin-type runs end once all eight stages hold data
      if (begin_type && wr_en && (fifo_fill_count_r == `DTB_FIFO_FULL - 4'h1)) begin
         state_nxt = dtb_pkg::st_idle;
      end
      // bytes sit in the low half during event-only runs
      wr_data   = event_only ? {8'h00, data_sel} : cof_addr;
      wptr_nxt  = wr_en ? wptr_r + 3'h1 : wptr_r;
      count_nxt = (wr_en && (fifo_fill_count_r != `DTB_FIFO_FULL)) ?
                  fifo_fill_count_r + 4'h1 : fifo_fill_count_r;
      ma_nxt    = match_a_flag_r || (running && a_ev);
      mb_nxt    = match_b_flag_r || (running && b_ev);
      if (arm) begin
         state_nxt = dtb_pkg::st_wait;
         wptr_nxt  = `DTB_PTR_RESET;
         count_nxt = `DTB_COUNT_RESET;
         ma_nxt    = 1'b0;
         mb_nxt    = 1'b0;
      end else if (stop) begin
         state_nxt = dtb_pkg::st_idle;
      end
      run_nxt = (state_nxt != dtb_pkg::st_idle);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r            <= '0;
         state_r           <= dtb_pkg::st_idle;
         wptr_r            <= `DTB_PTR_RESET;
         fifo_fill_count_r <= `DTB_COUNT_RESET;
         run_active_flag_r <= 1'b0;
         match_a_flag_r    <= 1'b0;
         match_b_flag_r    <= 1'b0;
      end else begin
         ctrl_r            <= ctrl_nxt;
         state_r           <= state_nxt;
         wptr_r            <= wptr_nxt;
         fifo_fill_count_r <= count_nxt;
         run_active_flag_r <= run_nxt;
         match_a_flag_r    <= ma_nxt;
         match_b_flag_r    <= mb_nxt;
      end
   end

   dtb_fifo_mem #(
      .WIDTH (16),
      .DEPTH (`DTB_FIFO_DEPTH),
      .AW    (3)
   ) u_mem (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .wr_en     (wr_en),
      .wr_idx    (wptr_r),
      .wr_data   (wr_data),
      .rd_idx    (fifo_rd_idx),
      .rd_data_r (fifo_rd_data_r)
   );

   // ********************************
   // opcode tags and cpu breakpoints
   // ********************************
   logic brk_on, tag_hit, ta_nxt, tb_nxt, tbrk_nxt, force_nxt, subst_nxt;
   logic [7:0] opc_nxt;

   // tags leave with the fetch; the queue drops them on a flush
   always_comb begin
      brk_on    = running && ctrl_r.cpu_break_enable;
      tag_hit   = full_mode ? a_addr :
                  mode_hit(mode, a_side, b_addr, match_a_flag_r);
      ta_nxt    = running && trig_cfg.fetch_qualify_select && bus.opfetch && a_side;
      tb_nxt    = running && trig_cfg.fetch_qualify_select && bus.opfetch && b_addr;
      tbrk_nxt  = brk_on && ctrl_r.breakpoint_kind_select && bus.opfetch && tag_hit;
      // a new request wins over an acknowledge in the same cycle
      force_nxt = (brk_on && !ctrl_r.breakpoint_kind_select && trig)
                  || (force_break_r && !break_ack);
      subst_nxt = exec_valid && exec_tag_brk;
      opc_nxt   = halt_mode_permit ? HALT_OPCODE : TRAP_OPCODE;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tag_a_r        <= 1'b0;
         tag_b_r        <= 1'b0;
         tag_brk_r      <= 1'b0;
         force_break_r  <= 1'b0;
         exec_subst_r   <= 1'b0;
         subst_opcode_r <= `DTB_OPCODE_RESET;
      end else begin
         tag_a_r        <= ta_nxt;
         tag_b_r        <= tb_nxt;
         tag_brk_r      <= tbrk_nxt;
         force_break_r  <= force_nxt;
         exec_subst_r   <= subst_nxt;
         subst_opcode_r <= opc_nxt;
      end
   end

   // ********************************
   // assertions
   // ********************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_arm_clears;
      arm |=> run_active_flag_r && !match_a_flag_r && !match_b_flag_r
              && (fifo_fill_count_r == 4'h0);
   endproperty
   a_arm_clears: assert property (p_arm_clears) else $error("arm did not reset status");

   property p_stop_now;
      stop |=> !run_active_flag_r && !wr_en;
   endproperty
   a_stop_now: assert property (p_stop_now) else $error("run not stopped");

   property p_full_ends;
      (begin_type && wr_en && !ctrl_wr && fifo_fill_count_r == 4'h7)
         |=> !run_active_flag_r && fifo_fill_count_r == 4'h8;
   endproperty
   a_full_ends: assert property (p_full_ends) else $error("full fifo did not end run");

   property p_end_trig;
      (state_r == dtb_pkg::st_wait && !begin_type && trig && !ctrl_wr) |=> !run_active_flag_r;
   endproperty
   a_end_trig: assert property (p_end_trig) else $error("end trace kept running");

   property p_subst;
      exec_valid && exec_tag_brk |=> exec_subst_r;
   endproperty
   a_subst: assert property (p_subst) else $error("tagged opcode not replaced");

   property p_no_subst;
      !(exec_valid && exec_tag_brk) |=> !exec_subst_r;
   endproperty
   a_no_subst: assert property (p_no_subst) else $error("replacement without execution");

   property p_force_hold;
      force_break_r && !break_ack |=> force_break_r;
   endproperty
   a_force_hold: assert property (p_force_hold) else $error("force request dropped");

   property p_trap;
      !halt_mode_permit |=> subst_opcode_r == TRAP_OPCODE;
   endproperty
   a_trap: assert property (p_trap) else $error("halt used without permission");

   property p_evonly_low;
      wr_en && event_only |-> wr_data[15:8] == 8'h00 && wr_data[7:0] == data_sel;
   endproperty
   a_evonly_low: assert property (p_evonly_low) else $error("event byte misplaced");

   property p_a_then_b;
      trig && mode == `DTB_MODE_A_THEN_B |-> match_a_flag_r;
   endproperty
   a_a_then_b: assert property (p_a_then_b) else $error("b fired before a");

   c_full: cover property (run_active_flag_r ##1 fifo_fill_count_r == 4'h8);
   c_force: cover property (force_break_r ##[1:20] break_ack);
   c_subst: cover property (exec_subst_r);
   c_end: cover property (state_r == dtb_pkg::st_wait && !begin_type && trig);

endmodule

`default_nettype wire

// >>> testbench/dtb_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none

// ********************************
// cpu instruction queue and break handshake, behavioural
// ********************************
module dtb_cpu_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       fetch_seen,
   input  wire logic       tag_a_r,
   input  wire logic       tag_b_r,
   input  wire logic       tag_brk_r,
   input  wire logic       force_break_r,
   input  wire logic       pop,
   input  wire logic       flush,
   input  wire logic [3:0] ack_wait,
   output logic            exec_valid,
   output logic            exec_tag_a,
   output logic            exec_tag_b,
   output logic            exec_tag_brk,
   output logic            break_ack
);
   logic [2:0] q[$];
   logic       fetch_d;
   logic [3:0] wait_ctr;

   // tags ride in the queue with their opcode; a flush drops them
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q.delete();
         fetch_d <= 1'b0;
         exec_valid <= 1'b0;
         {exec_tag_a, exec_tag_b, exec_tag_brk} <= 3'h0;
      end else begin
         fetch_d <= fetch_seen;
         if (pop && q.size() > 0) begin
            exec_valid <= 1'b1;
            {exec_tag_a, exec_tag_b, exec_tag_brk} <= q.pop_front();
         end else begin
            // idle tags toggle to expose unqualified use
            exec_valid <= 1'b0;
            {exec_tag_a, exec_tag_b, exec_tag_brk} <= ~{exec_tag_a, exec_tag_b, exec_tag_brk};
         end
         if (flush)
            q.delete();
         else if (fetch_d)
            q.push_back({tag_a_r, tag_b_r, tag_brk_r});
      end
   end

   // the request is taken once the current instruction ends
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         break_ack <= 1'b0;
         wait_ctr <= 4'h0;
      end else if (force_break_r && !break_ack && wait_ctr == ack_wait) begin
         break_ack <= 1'b1;
         wait_ctr <= 4'h0;
      end else begin
         break_ack <= 1'b0;
         wait_ctr <= (force_break_r && !break_ack) ? wait_ctr + 4'h1 : 4'h0;
      end
   end
endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dtb_defs.svh"

module tb_top;
   typedef struct packed {
      logic [3:0] mode; logic [15:0] pre; logic [15:0] addr;
      logic rw; logic [7:0] data; logic [3:0] dir; logic hit;
   } dtb_case_t;
   logic               ref_clk, rst_n, ctrl_wr, cof_valid, halt_mode_permit, pop, flush;
   dtb_pkg::dtb_ctrl_t ctrl_in;
   dtb_pkg::dtb_trig_t trig_cfg;
   dtb_pkg::dtb_bus_t  bus;
   logic [15:0]        comp_a_val, comp_b_val, cof_addr, fifo_rd_data_r;
   logic [2:0]         fifo_rd_idx;
   logic [3:0]         fifo_fill_count_r;
   logic [7:0]         subst_opcode_r;
   logic               exec_valid, exec_tag_a, exec_tag_b, exec_tag_brk, break_ack;
   logic               run_active_flag_r, match_a_flag_r, match_b_flag_r;
   logic               tag_a_r, tag_b_r, tag_brk_r, force_break_r, exec_subst_r;
   wire logic          fetch_seen = bus.valid & bus.opfetch;
   int                 n_fail, checked, cycles;
   dtb_case_t          cases [17] = '{
      '{`DTB_MODE_A_ONLY, 16'h0, 16'h1200, 1'b1, 8'h00, 4'h0, 1'b1},
      '{`DTB_MODE_A_ONLY, 16'h0, 16'h1201, 1'b1, 8'h00, 4'h0, 1'b0},
      '{`DTB_MODE_A_OR_B, 16'h0, 16'h12A5, 1'b1, 8'h00, 4'h0, 1'b1},
      '{`DTB_MODE_A_OR_B, 16'h0, 16'h12A5, 1'b0, 8'h00, 4'h3, 1'b0},
      '{`DTB_MODE_A_THEN_B, 16'h0, 16'h12A5, 1'b1, 8'h00, 4'h0, 1'b0},
      '{`DTB_MODE_A_THEN_B, 16'h1200, 16'h12A5, 1'b1, 8'h00, 4'h0, 1'b1},
      '{`DTB_MODE_FULL_AB, 16'h0, 16'h1200, 1'b1, 8'hA5, 4'h0, 1'b1},
      '{`DTB_MODE_FULL_AB, 16'h0, 16'h1200, 1'b1, 8'hA4, 4'h0, 1'b0},
      '{`DTB_MODE_FULL_AB, 16'h0, 16'h1200, 1'b0, 8'hA5, 4'h8, 1'b1},
      '{`DTB_MODE_FULL_AB, 16'h0, 16'h1200, 1'b1, 8'hA5, 4'h8, 1'b0},
      '{`DTB_MODE_FULL_ANB, 16'h0, 16'h1200, 1'b1, 8'hA4, 4'h0, 1'b1},
      '{`DTB_MODE_FULL_ANB, 16'h0, 16'h1200, 1'b1, 8'hA5, 4'h0, 1'b0},
      '{`DTB_MODE_INSIDE, 16'h0, 16'h1200, 1'b1, 8'h00, 4'h0, 1'b1},
      '{`DTB_MODE_INSIDE, 16'h0, 16'h12A6, 1'b1, 8'h00, 4'h0, 1'b0},
      '{`DTB_MODE_OUTSIDE, 16'h0, 16'h11FF, 1'b1, 8'h00, 4'h0, 1'b1},
      '{`DTB_MODE_OUTSIDE, 16'h0, 16'h12A5, 1'b1, 8'h00, 4'h0, 1'b0},
      '{4'h9, 16'h0, 16'h1200, 1'b1, 8'h00, 4'h0, 1'b0}};

   dtb_trigger_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
      .ctrl_in(ctrl_in), .trig_cfg(trig_cfg), .comp_a_val(comp_a_val), .comp_b_val(comp_b_val),
      .bus(bus), .cof_valid(cof_valid), .cof_addr(cof_addr), .exec_valid(exec_valid),
      .exec_tag_a(exec_tag_a), .exec_tag_b(exec_tag_b), .exec_tag_brk(exec_tag_brk),
      .break_ack(break_ack), .halt_mode_permit(halt_mode_permit), .fifo_rd_idx(fifo_rd_idx),
      .run_active_flag_r(run_active_flag_r), .match_a_flag_r(match_a_flag_r),
      .match_b_flag_r(match_b_flag_r), .fifo_fill_count_r(fifo_fill_count_r),
      .fifo_rd_data_r(fifo_rd_data_r), .tag_a_r(tag_a_r), .tag_b_r(tag_b_r),
      .tag_brk_r(tag_brk_r), .force_break_r(force_break_r), .exec_subst_r(exec_subst_r),
      .subst_opcode_r(subst_opcode_r));

   dtb_cpu_model cpu_u (.ref_clk(ref_clk), .rst_n(rst_n), .fetch_seen(fetch_seen),
      .tag_a_r(tag_a_r), .tag_b_r(tag_b_r), .tag_brk_r(tag_brk_r),
      .force_break_r(force_break_r), .pop(pop), .flush(flush), .ack_wait(4'h4),
      .exec_valid(exec_valid), .exec_tag_a(exec_tag_a), .exec_tag_b(exec_tag_b),
      .exec_tag_brk(exec_tag_brk), .break_ack(break_ack));

   // ********************************
   // clock, hang guard and reporting
   // ********************************
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask

   task automatic chkc(input logic [3:0] exp);
      chk(16'(fifo_fill_count_r), 16'(exp));
   endtask

   // ********************************
   // access tasks, all driven 10 ns after the rising edge
   // ********************************
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask

   task automatic arm(input dtb_pkg::dtb_trig_t t, input logic [3:0] dir = 4'h0,
                      input logic brk = 1'b0, tag = 1'b0, en = 1'b1, run = 1'b1);
      idle(1);
      ctrl_wr = 1'b1;
      ctrl_in = dtb_pkg::dtb_ctrl_t'({en, run, brk, tag, dir});
      trig_cfg = t;
      idle(1);
      ctrl_wr = 1'b0;
   endtask

   // one bus cycle; the released bus shows inverted junk
   task automatic bcyc(input logic [15:0] a, input logic rw = 1'b1, input logic [7:0] d = 8'h00,
                       input logic opf = 1'b0, cv = 1'b0, input logic [15:0] ca = 16'h0);
      idle(1);
      bus = '{1'b1, opf, rw, a, (rw ? d : ~d), d};
      cof_valid = cv;
      cof_addr = ca;
      idle(1);
      bus = {1'b0, ~bus[34:0]};
      cof_valid = 1'b0;
   endtask

   task automatic cofs(input int n, input logic [15:0] base);
      for (int i = 0; i < n; i++) begin
         idle(1);
         cof_valid = 1'b1;
         cof_addr = base + 16'(i);
      end
      idle(1);
      cof_valid = 1'b0;
      cof_addr = ~cof_addr;
   endtask

   task automatic rd(input logic [2:0] idx, input logic [15:0] exp);
      idle(1);
      fifo_rd_idx = idx;
      idle(2);
      chk(fifo_rd_data_r, exp);
   endtask

   task automatic qop(input logic do_pop);
      idle(1);
      pop = do_pop;
      flush = ~do_pop;
      idle(1);
      pop = 1'b0;
      flush = 1'b0;
      idle(1);
   endtask

   // ********************************
   // main sequence
   // ********************************
   initial begin
      {ctrl_wr, cof_valid, halt_mode_permit, pop, flush, rst_n} = 6'h00;
      {ctrl_in, trig_cfg, bus, fifo_rd_idx, cof_addr} = '0;
      comp_a_val = 16'h1200;
      comp_b_val = 16'h12A5;
      repeat (5) @(posedge ref_clk);
      #10 rst_n = 1'b1;
      chkb(run_active_flag_r, 1'b0);
      // end trace probes: the run ends when the mode fires
      foreach (cases[i]) begin
         arm('{cases[i].mode, 1'b0, 1'b0}, cases[i].dir);
         chk(16'({match_a_flag_r, match_b_flag_r}), 16'h0000);
         if (cases[i].pre != 16'h0)
            bcyc(cases[i].pre);
         bcyc(cases[i].addr, cases[i].rw, cases[i].data);
         idle(2);
         chkb(run_active_flag_r, !cases[i].hit);
         chkb(force_break_r, 1'b0);
      end
      // begin trace: nothing stored before the hit, full at eight entries
      arm('{`DTB_MODE_A_ONLY, 1'b0, 1'b1});
      cofs(1, 16'h5000);
      chkc(4'h0);
      bcyc(16'h1200);
      cofs(8, 16'h4000);
      idle(1);
      chkc(4'h8);
      chkb(run_active_flag_r, 1'b0);
      rd(3'h0, 16'h4000);
      rd(3'h7, 16'h4007);
      // end trace stores up to and including the trigger
      arm('{`DTB_MODE_A_OR_B, 1'b0, 1'b0});
      cofs(3, 16'h6000);
      bcyc(16'h12A5, 1'b1, 8'h00, 1'b0, 1'b1, 16'h6003);
      idle(2);
      chkc(4'h4);
      rd(3'h3, 16'h6003);
      // manual stop by enable, then by run control
      for (int s = 0; s < 2; s++) begin
         arm('{`DTB_MODE_A_ONLY, 1'b0, 1'b1});
         bcyc(16'h1200);
         cofs(3, 16'h7000);
         arm('{`DTB_MODE_A_ONLY, 1'b0, 1'b1}, 4'h0, 1'b0, 1'b0, s[0], ~s[0]);
         cofs(2, 16'h7100);
         chkb(run_active_flag_r, 1'b0);
         chkc(4'h3);
      end
      // event-only b ignores end trace select
      arm('{`DTB_MODE_EV_B, 1'b0, 1'b0});
      for (int i = 0; i < 8; i++)
         bcyc(16'h12A5, 1'b1, 8'h30 + 8'(i));
      idle(1);
      chkc(4'h8);
      chkb(run_active_flag_r, 1'b0);
      rd(3'h7, 16'h0037);
      arm('{`DTB_MODE_A_THEN_EV_B, 1'b0, 1'b1});
      bcyc(16'h12A5, 1'b1, 8'h11);
      bcyc(16'h1200, 1'b1, 8'h22);
      bcyc(16'h12A5, 1'b1, 8'h55);
      idle(2);
      chkc(4'h1);
      rd(3'h0, 16'h0055);
      // force break held until acknowledged
      arm('{`DTB_MODE_A_ONLY, 1'b0, 1'b1}, 4'h0, 1'b1);
      bcyc(16'h1200);
      idle(1);
      chkb(force_break_r, 1'b1);
      idle(2);
      chkb(force_break_r, 1'b1);
      idle(4);
      chkb(force_break_r, 1'b0);
      // full-mode tag break on address alone; flushed opcodes never act
      for (int p = 0; p < 2; p++) begin
         halt_mode_permit = p[0];
         arm('{`DTB_MODE_FULL_AB, 1'b0, 1'b1}, 4'h0, 1'b1, 1'b1);
         bcyc(16'h1300, 1'b1, 8'h00, 1'b1);
         bcyc(16'h1200, 1'b1, 8'h00, 1'b1);
         chkb(tag_brk_r, 1'b1);
         qop(1'b1);
         chkb(exec_subst_r, 1'b0);
         qop(1'b0);
         qop(1'b1);
         chkb(exec_subst_r, 1'b0);
         bcyc(16'h1200, 1'b1, 8'h00, 1'b1);
         qop(1'b1);
         chkb(exec_subst_r, 1'b1);
         chk(16'(subst_opcode_r), p ? 16'h0001 : 16'h0002);
         chkb(force_break_r, 1'b0);
      end
      // tracked trigger fires only on execution
      arm('{`DTB_MODE_A_ONLY, 1'b1, 1'b0});
      bcyc(16'h1200, 1'b1, 8'h00, 1'b1);
      chk(16'({tag_a_r, tag_b_r}), 16'h0002);
      idle(2);
      chkb(run_active_flag_r, 1'b1);
      qop(1'b1);
      idle(2);
      chkb(run_active_flag_r, 1'b0);
      give_verdict();
   end
endmodule

`default_nettype wire
